//--- rtl/rer_defines.svh
`ifndef RER_DEFINES_SVH
`define RER_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RER_OFF_CTRL 12'h000
`define RER_OFF_IRQ_STATUS 12'h004
`define RER_OFF_IRQ_MASK 12'h008
`define RER_OFF_GSR_LO 12'h010
`define RER_OFF_GSR_HI 12'h014
`define RER_OFF_SEL 12'h020
`define RER_OFF_REC_STATUS 12'h024
`define RER_OFF_MISC0 12'h028
`define RER_OFF_MISC1_LO 12'h030
`define RER_OFF_MISC1_HI 12'h034

// ----------------------------------------
// field positions
// ----------------------------------------
`define RER_ST_V_BIT 31
`define RER_ST_MV_BIT 26
`define RER_ST_IMPL_SYNDROME_CODE_LSB 8
`define RER_ST_ARCHITECTURAL_ERROR_CODE_LSB 0
`define RER_CTRL_NSE_BIT 0
`define RER_IRQ_CE_BIT 0
`define RER_IRQ_UE_BIT 1
`define RER_IRQ_ITS_BIT 2

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define RER_IMPL_SYNDROME_CODE_REAL 8'h00
`define RER_IMPL_SYNDROME_CODE_INJECTED 8'h01
`define RER_ARCHITECTURAL_ERROR_CODE_ITS_RAM 8'h06
`define RER_ARCHITECTURAL_ERROR_CODE_RAM 8'h07
`define RER_ARCHITECTURAL_ERROR_CODE_ITS_CMD 8'h01
`define RER_REC_VSRCH_CE 6'h17
`define RER_REC_VSRCH_UE 6'h18
`define RER_REC_ITS_CE 6'h19
`define RER_REC_ITS_UE 6'h1a
`define RER_REC_ITS_CMD 6'h1b
`define RER_REC_CC_CE 6'h3e
`define RER_REC_CC_UE 6'h3f
`define RER_REC_LPI_UE 6'h0a
`define RER_REC_TGT_UE 6'h0e
`define RER_MISC0_W 24
`define RER_IRQ_W 3
`define RER_CTRL_RESET 1'h0
`define RER_MASK_RESET 3'h0
`define RER_RESP_OKAY 2'h0
`define RER_RESP_SLVERR 2'h2

`endif

//--- rtl/rer_error_records.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rer_defines.svh"

// Contract
// R01 - syndrome 0x00 real, 0x01 injected
// R02 - translation RAM records 25,26 code 0x6
// R03 - records 23,24,62,63 report code 0x7
// R04 - records 27 to 61 code 0x1, 24-bit syndrome
// R05 - first misc packed from bit 0
// R06 - security setting zero: secure access only; non-secure reads of control, irq, select and status still return data
// R07 - captured data only on three records
// R08 - captured data ignores writes while misc valid
// R09 - uncorrectable error captures corrupted RAM word
// R10 - captured width follows RAM, upper zero
// R11 - group bit set while record reports
// R12 - group width follows configured record count
// R13 - group covers RAM, command, software records
// R14 - group bit derived from status valid
module rer_error_records #(
  parameter int DATA_W = 40,
  parameter int NUM_ITS_CMD = 1,
  parameter bit CC_PRESENT = 1'b1,
  parameter logic [5:0] SWINFO_REC = 6'h1a
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic err_valid,
  input wire logic [5:0] err_record,
  input wire logic err_injected,
  input wire logic err_non_arch,
  input wire logic [23:0] err_syndrome,
  input wire logic [DATA_W-1:0] err_word,
  output logic irq
);

  localparam int NREC = 64;
  localparam int LAST_CMD = 27 + NUM_ITS_CMD - 1;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [NREC-1:0] valid_reg;
  logic [NREC-1:0] mv_reg;
  logic [NREC-1:0] impl_syndrome_code_reg;
  logic [NREC-1:0] present;
  logic [DATA_W-1:0] cap_reg [3];
  logic ctrl_nse_reg;
  logic [`RER_IRQ_W-1:0] irq_status_reg;
  logic [`RER_IRQ_W-1:0] irq_mask_reg;
  logic [5:0] sel_reg;
  logic aw_held;
  logic w_held;
  logic [11:0] awaddr_q;
  logic aw_secure_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic ar_take;
  logic wr_gated;
  logic rd_gated;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_value;
  logic [NREC-1:0] gsr;
  logic clr_valid;
  logic ev_take;
  logic ev_new;
  logic [63:0] cap_view;
  rer_pkg::rer_slot_t ev_slot;
  rer_pkg::rer_slot_t sel_slot;

  rer_mem_if mem_bus ();

  rer_misc_mem #(
    .DEPTH(NREC)
  ) u_mem (
    .aclk(aclk),
    .port(mem_bus.mem)
  );

  // ----------------------------------------
  // record decode
  // ----------------------------------------
  function automatic rer_pkg::rer_code_t architectural_error_code_of(input logic [5:0] rec);
    rer_pkg::rer_code_t code;
    code = `RER_ARCHITECTURAL_ERROR_CODE_RAM;
    if (rec == `RER_REC_ITS_CE || rec == `RER_REC_ITS_UE)
    begin
      code = `RER_ARCHITECTURAL_ERROR_CODE_ITS_RAM; // R02
    end
    else if (rec == `RER_REC_VSRCH_CE || rec == `RER_REC_VSRCH_UE || rec == `RER_REC_CC_CE || rec == `RER_REC_CC_UE)
    begin
      code = `RER_ARCHITECTURAL_ERROR_CODE_RAM; // R03
    end
    else if (rec >= `RER_REC_ITS_CMD)
    begin
      code = `RER_ARCHITECTURAL_ERROR_CODE_ITS_CMD; // R04
    end
    return code;
  endfunction : architectural_error_code_of

  // only three records own a captured-data register; the rest have none
  function automatic rer_pkg::rer_slot_t slot_of(input logic [5:0] rec);
    rer_pkg::rer_slot_t s;
    s = rer_pkg::RER_SLOT_NONE;
    if (rec == `RER_REC_LPI_UE)
    begin
      s = rer_pkg::RER_SLOT_LPI; // R07
    end
    else if (rec == `RER_REC_TGT_UE)
    begin
      s = rer_pkg::RER_SLOT_TGT; // R07
    end
    else if (rec == SWINFO_REC)
    begin
      s = rer_pkg::RER_SLOT_SWINFO; // R07
    end
    return s;
  endfunction : slot_of

  genvar gi;
  generate
    for (gi = 0; gi < NREC; gi++)
    begin : g_present
      assign present[gi] = (gi <= LAST_CMD) || (CC_PRESENT && gi >= 62); // R12
    end
  endgenerate

  assign ev_take = err_valid && present[err_record];
  // a clear of the same record in this cycle frees it for the new error
  assign ev_new = ev_take && (!valid_reg[err_record] || (clr_valid && sel_reg == err_record));
  assign ev_slot = slot_of(err_record);
  assign sel_slot = slot_of(sel_reg);
  assign gsr = valid_reg & present; // R11 R13 R14

  // ----------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // prot[1] low marks a secure access
  assign wr_gated = !ctrl_nse_reg && aw_secure_q == 1'b0; // R06
  assign rd_gated = !ctrl_nse_reg && s_axi_arprot[1]; // R06

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_q <= 12'h000;
      aw_secure_q <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
      aw_secure_q <= !s_axi_awprot[1];
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
    else if (!aw_held && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
    else if (!w_held && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb
  begin
    wr_hit = 1'b1;
    if (awaddr_q == `RER_OFF_CTRL || awaddr_q == `RER_OFF_IRQ_STATUS || awaddr_q == `RER_OFF_IRQ_MASK)
    begin
      wr_hit = 1'b1;
    end
    else if (awaddr_q == `RER_OFF_SEL || awaddr_q == `RER_OFF_REC_STATUS)
    begin
      wr_hit = 1'b1;
    end
    else if (awaddr_q == `RER_OFF_MISC1_LO || awaddr_q == `RER_OFF_MISC1_HI)
    begin
      wr_hit = 1'b1;
    end
    else if (awaddr_q == `RER_OFF_GSR_LO || awaddr_q == `RER_OFF_GSR_HI || awaddr_q == `RER_OFF_MISC0)
    begin
      wr_hit = 1'b1;
    end
    else
    begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RER_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RER_RESP_OKAY : `RER_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // a non-secure write is dropped when the page is secure only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_nse_reg <= `RER_CTRL_RESET;
      irq_mask_reg <= `RER_MASK_RESET;
      sel_reg <= 6'h00;
    end
    else if (do_write && !wr_gated && wstrb_q[0])
    begin
      if (awaddr_q == `RER_OFF_CTRL)
      begin
        ctrl_nse_reg <= wdata_q[`RER_CTRL_NSE_BIT];
      end
      else if (awaddr_q == `RER_OFF_IRQ_MASK)
      begin
        irq_mask_reg <= wdata_q[`RER_IRQ_W-1:0];
      end
      else if (awaddr_q == `RER_OFF_SEL)
      begin
        sel_reg <= wdata_q[5:0];
      end
    end
  end

  assign clr_valid = do_write && !wr_gated && awaddr_q == `RER_OFF_REC_STATUS && wstrb_q[3] &&
                     wdata_q[`RER_ST_V_BIT];

  generate
    for (gi = 0; gi < NREC; gi++)
    begin : g_rec
      // a new error wins over a clear in the same cycle
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          valid_reg[gi] <= 1'b0;
          mv_reg[gi] <= 1'b0;
          impl_syndrome_code_reg[gi] <= 1'b0;
        end
        else if (ev_new && err_record == gi)
        begin
          valid_reg[gi] <= 1'b1;
          mv_reg[gi] <= 1'b1;
          impl_syndrome_code_reg[gi] <= (gi >= 27 && gi <= LAST_CMD) ? err_non_arch : err_injected; // R01 R04
        end
        else if (clr_valid && sel_reg == gi)
        begin
          valid_reg[gi] <= 1'b0;
          mv_reg[gi] <= 1'b0;
        end
      end
    end
    for (gi = 0; gi < 3; gi++)
    begin : g_cap
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cap_reg[gi] <= '0;
        end
        else if (ev_new && ev_slot == gi)
        begin
          cap_reg[gi] <= err_word; // R09
        end
        else if (do_write && !wr_gated && sel_slot == gi && !mv_reg[sel_reg] && awaddr_q == `RER_OFF_MISC1_LO) // R08
        begin
          cap_reg[gi] <= DATA_W'({32'h00000000, wdata_q}); // R10
        end
      end
    end
  endgenerate

  assign mem_bus.we = ev_new;
  assign mem_bus.waddr = err_record;
  assign mem_bus.wdata = err_syndrome; // R04 R05
  assign mem_bus.raddr = sel_reg;

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status_reg <= '0;
    end
    else
    begin
      for (int b = 0; b < `RER_IRQ_W; b++)
      begin
        if (ev_take && ((b == `RER_IRQ_ITS_BIT && err_record >= `RER_REC_ITS_CMD && err_record < `RER_REC_CC_CE) ||
            (b == `RER_IRQ_UE_BIT && err_record[0] == 1'b0 && err_record < `RER_REC_ITS_CMD) ||
            (b == `RER_IRQ_UE_BIT && err_record == `RER_REC_CC_UE) ||
            (b == `RER_IRQ_CE_BIT && err_record[0] && err_record < `RER_REC_ITS_CMD) ||
            (b == `RER_IRQ_CE_BIT && err_record == `RER_REC_CC_CE)))
        begin
          irq_status_reg[b] <= 1'b1;
        end
        else if (do_write && !wr_gated && awaddr_q == `RER_OFF_IRQ_STATUS && wstrb_q[0] && wdata_q[b])
        begin
          irq_status_reg[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  assign cap_view = (sel_slot == rer_pkg::RER_SLOT_NONE) ? 64'h0 : 64'(cap_reg[sel_slot[1:0]]); // R10

  always_comb
  begin
    rd_hit = 1'b1;
    rd_value = 32'h00000000;
    if (s_axi_araddr == `RER_OFF_CTRL)
    begin
      rd_value = {31'h00000000, ctrl_nse_reg};
    end
    else if (s_axi_araddr == `RER_OFF_IRQ_STATUS)
    begin
      rd_value = {29'h00000000, irq_status_reg};
    end
    else if (s_axi_araddr == `RER_OFF_IRQ_MASK)
    begin
      rd_value = {29'h00000000, irq_mask_reg};
    end
    else if (s_axi_araddr == `RER_OFF_SEL)
    begin
      rd_value = {26'h0000000, sel_reg};
    end
    else if (s_axi_araddr == `RER_OFF_GSR_LO)
    begin
      rd_value = rd_gated ? 32'h00000000 : gsr[31:0]; // R06 R11
    end
    else if (s_axi_araddr == `RER_OFF_GSR_HI)
    begin
      rd_value = rd_gated ? 32'h00000000 : gsr[63:32]; // R06 R11
    end
    else if (s_axi_araddr == `RER_OFF_REC_STATUS)
    begin
      rd_value = {valid_reg[sel_reg], 4'h0, mv_reg[sel_reg], 10'h000, 7'h00, impl_syndrome_code_reg[sel_reg],
                  architectural_error_code_of(sel_reg)}; // R01 R02 R03
    end
    else if (s_axi_araddr == `RER_OFF_MISC0)
    begin
      rd_value = rd_gated ? 32'h00000000 : {8'h00, mem_bus.rdata}; // R05 R06
    end
    else if (s_axi_araddr == `RER_OFF_MISC1_LO)
    begin
      rd_value = rd_gated ? 32'h00000000 : cap_view[31:0]; // R06
    end
    else if (s_axi_araddr == `RER_OFF_MISC1_HI)
    begin
      rd_value = rd_gated ? 32'h00000000 : cap_view[63:32]; // R06
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RER_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? `RER_RESP_OKAY : `RER_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (!s_axi_rvalid)
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : rer_error_records

`default_nettype wire

//--- rtl/rer_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rer_mem_if;
  logic we;
  rer_pkg::rer_rec_t waddr;
  rer_pkg::rer_misc0_t wdata;
  rer_pkg::rer_rec_t raddr;
  rer_pkg::rer_misc0_t rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rer_mem_if

`default_nettype wire

//--- rtl/rer_misc_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// per-record syndrome store, registered read
// ----------------------------------------
module rer_misc_mem #(
  parameter int DEPTH = 64
)(
  input wire logic aclk,
  rer_mem_if.mem port
);

  rer_pkg::rer_misc0_t store [DEPTH];

  always_ff @(posedge aclk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge aclk)
  begin
    port.rdata <= store[port.raddr];
  end

endmodule : rer_misc_mem

`default_nettype wire

//--- rtl/rer_pkg.sv
package rer_pkg;

  typedef logic [5:0] rer_rec_t;
  typedef logic [7:0] rer_code_t;
  typedef logic [23:0] rer_misc0_t;

  typedef enum logic [1:0]
  {
    RER_SLOT_LPI = 2'b00,
    RER_SLOT_TGT = 2'b01,
    RER_SLOT_SWINFO = 2'b10,
    RER_SLOT_NONE = 2'b11
  } rer_slot_t;

endpackage : rer_pkg

//--- verification/rer_error_records_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rer_defines.svh"
module rer_error_records_asserts #(
  parameter int DATA_W = 40,
  parameter int NUM_ITS_CMD = 1
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // ----------------------------------------
  // address of the read in flight, so data can be judged by register
  // ----------------------------------------
  logic [11:0] ra_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ra_reg <= 12'h0;
    else if (s_axi_arvalid && s_axi_arready)
      ra_reg <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stands: assert property (p_b_stands) else $error("write response dropped early");
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_stands: assert property (p_r_stands) else $error("read data dropped early");
  property p_misc0_pad;
    s_axi_rvalid && ra_reg == `RER_OFF_MISC0 |-> s_axi_rdata[31:24] == 8'h0;
  endproperty
  a_misc0_pad: assert property (p_misc0_pad) else $error("first misc upper bits set");
  property p_misc1_pad;
    s_axi_rvalid && ra_reg == `RER_OFF_MISC1_HI |-> (s_axi_rdata >> (DATA_W - 32)) == 32'h0;
  endproperty
  a_misc1_pad: assert property (p_misc1_pad) else $error("captured data above width");
  property p_gsr_lo;
    s_axi_rvalid && ra_reg == `RER_OFF_GSR_LO |-> (s_axi_rdata >> (27 + NUM_ITS_CMD)) == 32'h0;
  endproperty
  a_gsr_lo: assert property (p_gsr_lo) else $error("group bit of absent record");
  property p_gsr_hi;
    s_axi_rvalid && ra_reg == `RER_OFF_GSR_HI |-> s_axi_rdata[29:0] == 30'h0;
  endproperty
  a_gsr_hi: assert property (p_gsr_hi) else $error("group bit of absent high record");
  property p_status_fields;
    s_axi_rvalid && ra_reg == `RER_OFF_REC_STATUS |-> s_axi_rdata[30:27] == 4'h0 && s_axi_rdata[25:9] == 17'h0;
  endproperty
  a_status_fields: assert property (p_status_fields) else $error("syndrome out of range");
  property p_status_code;
    s_axi_rvalid && ra_reg == `RER_OFF_REC_STATUS && s_axi_rdata[31] |-> s_axi_rdata[7:0] inside {8'h01, 8'h06, 8'h07};
  endproperty
  a_status_code: assert property (p_status_code) else $error("bad error code");
endmodule : rer_error_records_asserts

bind rer_error_records rer_error_records_asserts #(.DATA_W(DATA_W), .NUM_ITS_CMD(NUM_ITS_CMD)) u_asserts (.*);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rer_defines.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_q;
  logic err_valid = 1'b0;
  logic err_injected = 1'b0;
  logic err_non_arch = 1'b0;
  logic [5:0] err_record = 6'h0;
  logic [23:0] err_syndrome = 24'h0;
  logic [39:0] err_word = 40'h0;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] m_st [64];
  logic [23:0] m_m0 [64];
  logic [39:0] m_m1 [64];
  logic [2:0] m_irq = 3'h0;
  int recs [$] = '{0, 9, 10, 14, 23, 24, 25, 26, 27, 40, 62, 63};

  always #20 aclk = ~aclk;

  rer_error_records #(.DATA_W(40), .NUM_ITS_CMD(1)) dut (.*);

  // ----------------------------------------
  // bus tasks and model; every handshake wait is bounded by tick
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask : tick

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic ns = 1'b0,
                        input logic [1:0] er = `RER_RESP_OKAY);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awprot <= {1'b0, ns, 1'b0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w)
    begin
      tick(n);
      if (aw && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
    end
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do
      tick(n);
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ns = 1'b0,
                        input logic [1:0] er = `RER_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arprot <= {1'b0, ns, 1'b0};
    s_axi_arvalid <= 1'b1;
    do
      tick(n);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do
      tick(n);
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd_chk

  task automatic fire(input int r);
    logic inj;
    logic na;
    logic [23:0] s;
    logic [39:0] w;
    inj = 1'($urandom);
    na = 1'($urandom);
    s = 24'($urandom);
    w = {8'($urandom), $urandom};
    err_valid <= 1'b1;
    err_record <= 6'(r);
    err_injected <= inj;
    err_non_arch <= na;
    err_syndrome <= s;
    err_word <= w;
    @(posedge aclk);
    err_valid <= 1'b0;
    @(posedge aclk);
    // absent records and already reporting ones keep their first error
    if ((r < 28 || r > 61) && m_st[r][31] !== 1'b1)
    begin
      m_st[r] = {1'b1, 4'h0, 1'b1, 17'h0, r == 27 ? na : inj,
                 r == 25 || r == 26 ? 8'h06 : r == 27 ? 8'h01 : 8'h07};
      m_m0[r] = s;
      if (r == 10 || r == 14 || r == 26) m_m1[r] = w;
      m_irq[r == 27 ? 2 : (r == 62 || (r < 27 && r % 2 == 1)) ? 0 : 1] = 1'b1;
    end
  endtask : fire

  task automatic chk_rec(input int r);
    axi_wr(`RER_OFF_SEL, 32'(r));
    rd_chk(`RER_OFF_REC_STATUS, m_st[r]);
    rd_chk(`RER_OFF_MISC0, {8'h0, m_m0[r]});
    rd_chk(`RER_OFF_MISC1_LO, m_m1[r][31:0]);
    rd_chk(`RER_OFF_MISC1_HI, {24'h0, m_m1[r][39:32]});
  endtask : chk_rec

  task automatic chk_gsr(input logic ns);
    logic [63:0] g;
    for (int i = 0; i < 64; i++) g[i] = m_st[i][31];
    rd_chk(`RER_OFF_GSR_LO, g[31:0], ns);
    rd_chk(`RER_OFF_GSR_HI, g[63:32], ns);
  endtask : chk_gsr

  initial
  begin
    void'($urandom(32'hc237eeb4));
    foreach (m_st[i]) m_st[i] = 32'h0;
    foreach (m_m1[i]) m_m1[i] = 40'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`RER_OFF_CTRL, 32'h0);
    rd_chk(`RER_OFF_IRQ_MASK, 32'h0);
    rd_chk(`RER_OFF_IRQ_STATUS, 32'h0);
    chk_gsr(1'b0);
    rd_chk(12'h040, 32'h0, 1'b0, `RER_RESP_SLVERR);
    axi_wr(12'h040, 32'h1, 1'b0, `RER_RESP_SLVERR);
    $display("test reset done");
    foreach (recs[i]) fire(recs[i]);
    fire(25);
    foreach (recs[i]) if (recs[i] != 40) chk_rec(recs[i]);
    chk_gsr(1'b0);
    $display("test events done");
    axi_wr(`RER_OFF_SEL, 32'ha);
    axi_wr(`RER_OFF_MISC1_LO, 32'h5a5a5a5a);
    rd_chk(`RER_OFF_MISC1_LO, m_m1[10][31:0]);
    axi_wr(`RER_OFF_REC_STATUS, 32'h80000000);
    // clearing drops valid and misc-valid; syndrome and code fields keep their values
    m_st[10] = m_st[10] & 32'h7bffffff;
    rd_chk(`RER_OFF_REC_STATUS, m_st[10]);
    chk_gsr(1'b0);
    axi_wr(`RER_OFF_MISC1_LO, 32'h5a5a5a5a);
    rd_chk(`RER_OFF_MISC1_LO, 32'h5a5a5a5a);
    rd_chk(`RER_OFF_MISC1_HI, 32'h0);
    $display("test captured data done");
    rd_chk(`RER_OFF_GSR_LO, 32'h0, 1'b1);
    rd_chk(`RER_OFF_MISC1_LO, 32'h0, 1'b1);
    axi_wr(`RER_OFF_CTRL, 32'h1, 1'b1);
    rd_chk(`RER_OFF_CTRL, 32'h0);
    axi_wr(`RER_OFF_CTRL, 32'h1);
    chk_gsr(1'b1);
    rd_chk(`RER_OFF_MISC1_LO, 32'h5a5a5a5a, 1'b1);
    $display("test security done");
    rd_chk(`RER_OFF_IRQ_STATUS, {29'h0, m_irq});
    chk({31'h0, irq}, 32'h0);
    axi_wr(`RER_OFF_IRQ_MASK, 32'h7);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    axi_wr(`RER_OFF_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`RER_OFF_IRQ_STATUS, 32'h0);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
